// ==== core_regs_pkg.sv ====
// Register map, field positions and reset values of the core special-function registers
package core_regs_pkg;

	localparam logic [7:0] ADDR_CPU_STATUS      = 8'h03;
	localparam logic [7:0] ADDR_CPU_STATUS_HI   = 8'h83;
	localparam logic [7:0] ADDR_IRQ_CONTROL     = 8'h0B;
	localparam logic [7:0] ADDR_IRQ_CONTROL_HI  = 8'h8B;
	localparam logic [7:0] ADDR_TIMER_OPTION    = 8'h81;
	localparam logic [7:0] ADDR_PERIPH_ENABLE   = 8'h8C;
	localparam logic [7:0] ADDR_PERIPH_FLAGS    = 8'h0C;

	// Status fields
	localparam int ST_CARRY  = 0;
	localparam int ST_DCARRY = 1;
	localparam int ST_ZERO   = 2;
	localparam int ST_SLEEPN = 3;
	localparam int ST_WDOGN  = 4;
	localparam int ST_BANK   = 5;

	// Option fields
	localparam int OP_RATE_LO = 0;
	localparam int OP_PSA     = 3;
	localparam int OP_TIMER0_EDGE_SELECT    = 4;
	localparam int OP_TIMER0_CLOCK_SOURCE    = 5;
	localparam int OP_EDGE    = 6;
	localparam int OP_PUOFF   = 7;

	// Interrupt control fields
	localparam int IC_PCF   = 0;
	localparam int IC_EXTF  = 1;
	localparam int IC_T0F   = 2;
	localparam int IC_PCE   = 3;
	localparam int IC_EXTE  = 4;
	localparam int IC_T0E   = 5;
	localparam int IC_PERIPHERAL_IRQ_GATE  = 6;
	localparam int IC_GIE   = 7;

	localparam logic [7:0] STATUS_RESET     = 8'h18;
	localparam logic [7:0] OPTION_RESET     = 8'hFF;
	localparam logic [7:0] IRQCTL_RESET     = 8'h00;
	localparam logic [7:0] PERIPH_RESET     = 8'h00;
	localparam logic [7:0] PERIPH_IMPL_MASK = 8'hEF;
	localparam logic [7:0] STATUS_WR_MASK   = 8'hE0;

	typedef enum logic [1:0] {
		ALU_LOGIC,
		ALU_ADD,
		ALU_SUB
	} alu_kind_e;

	// One executed instruction's effect on the status register
	typedef struct packed {
		logic       valid;
		logic       dest_status;
		logic [7:0] wr_data;
		logic       upd_zero;
		logic       upd_carries;
		alu_kind_e  kind;
		logic [7:0] opa;
		logic [7:0] opb;
		logic [7:0] logic_result;
	} alu_op_s;

	typedef struct packed {
		logic wdog_clear;
		logic sleep;
		logic wdog_timeout;
	} core_event_s;

endpackage : core_regs_pkg

// ==== prescaler_unit.sv ====
// Shared prescaler routed to timer0 or the watchdog
`timescale 1ns/1ps
module prescaler_unit
	import core_regs_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       tick_in,
	input  wire logic [2:0] rate,
	input  wire logic       to_watchdog,
	output logic            tick_out
);

	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] limit;
	logic [3:0]       shift;

	always_comb begin
		shift = to_watchdog ? {1'b0, rate} : ({1'b0, rate} + 4'h1);
		limit = WIDTH'((9'h001 << shift) - 9'h001);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count_r  <= '0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (tick_in) begin
				if ((count_r & limit) == limit) begin
					count_r  <= '0;
					tick_out <= 1'b1;
				end else begin
					count_r <= count_r + WIDTH'(1);
				end
			end
		end
	end

endmodule : prescaler_unit

// ==== core_status_option_irq_regs.sv ====
// Core status, option and interrupt control registers
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module core_status_option_irq_regs
	import core_regs_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic [7:0]       reg_rdata,
	input  wire alu_op_s     alu_op,
	input  wire core_event_s core_event,
	input  wire logic        ext_irq_pin,
	input  wire logic        timer0_clock_pin,
	input  wire logic [5:0]  port_pins,
	input  wire logic [5:0]  per_pin_change_mask,
	input  wire logic [5:0]  weak_pullup_enable,
	input  wire logic [7:0]  periph_events,
	input  wire logic        watchdog_tick,
	output logic             bank_select,
	output logic [5:0]       pullup_on,
	output logic [7:0]       timer0,
	output logic             watchdog_tick_scaled,
	output logic             cpu_irq
);

	////////////////////////////////////////////////////////////////////////
	logic [7:0] status_r;
	logic [7:0] option_r;
	logic [7:0] irqctl_r;
	logic [7:0] pie_r;
	logic [7:0] pir_r;
	logic [7:0] timer0_r;
	logic       ext_pin_d_r;
	logic       t0_pin_d_r;
	logic [5:0] port_d_r;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = reg_write && (reg_addr == a || reg_addr == b);
	endfunction : hit

	logic wr_status;
	logic wr_option;
	logic wr_irqctl;
	logic wr_pie;
	logic wr_pir;
	assign wr_status = hit(ADDR_CPU_STATUS, ADDR_CPU_STATUS_HI);
	assign wr_option = hit(ADDR_TIMER_OPTION, ADDR_TIMER_OPTION);
	assign wr_irqctl = hit(ADDR_IRQ_CONTROL, ADDR_IRQ_CONTROL_HI);
	assign wr_pie    = hit(ADDR_PERIPH_ENABLE, ADDR_PERIPH_ENABLE);
	assign wr_pir    = hit(ADDR_PERIPH_FLAGS, ADDR_PERIPH_FLAGS);

	////////////////////////////////////////////////////////////////////////
	// ALU flag computation
	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [7:0] opb_eff;
	logic       cin;
	logic [7:0] result;

	always_comb begin
		opb_eff = (alu_op.kind == ALU_SUB) ? ~alu_op.opb : alu_op.opb;
		cin     = (alu_op.kind == ALU_SUB);
		sum9    = {1'b0, alu_op.opa} + {1'b0, opb_eff} + {8'h00, cin};
		sum5    = {1'b0, alu_op.opa[3:0]} + {1'b0, opb_eff[3:0]} + {4'h0, cin};
		result  = (alu_op.kind == ALU_LOGIC) ? alu_op.logic_result : sum9[7:0];
	end

	////////////////////////////////////////////////////////////////////////
	// Status register
	always_ff @(posedge clk) begin
		if (reset) begin
			status_r <= STATUS_RESET;
		end else begin
			if (alu_op.valid && alu_op.dest_status) begin
				// Bank and reserved bits always take the written value; the hardware flags at bits 4:3 never do
				status_r[7:5] <= alu_op.wr_data[7:5];
			end else if (wr_status) begin
				status_r[7:5] <= reg_wdata[7:5];
			end
			if (alu_op.valid && alu_op.upd_zero) begin
				status_r[ST_ZERO] <= (result == 8'h00);
			end else if (alu_op.valid && alu_op.dest_status && !alu_op.upd_carries) begin
				status_r[ST_ZERO] <= alu_op.wr_data[ST_ZERO];
			end else if (wr_status) begin
				status_r[ST_ZERO] <= reg_wdata[ST_ZERO];
			end
			if (alu_op.valid && alu_op.upd_carries && alu_op.kind != ALU_LOGIC) begin
				status_r[ST_CARRY]  <= sum9[8];
				status_r[ST_DCARRY] <= sum5[4];
			end else if (alu_op.valid && alu_op.dest_status && !alu_op.upd_zero) begin
				status_r[1:0] <= alu_op.wr_data[1:0];
			end else if (wr_status) begin
				status_r[1:0] <= reg_wdata[1:0];
			end
			if (core_event.wdog_timeout) begin
				status_r[ST_WDOGN] <= 1'b0;
			end else if (core_event.wdog_clear || core_event.sleep) begin
				status_r[ST_WDOGN] <= 1'b1;
			end
			if (core_event.sleep) begin
				status_r[ST_SLEEPN] <= 1'b0;
			end else if (core_event.wdog_clear) begin
				status_r[ST_SLEEPN] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Option register
	always_ff @(posedge clk) begin
		if (reset) begin
			option_r <= OPTION_RESET;
		end else if (wr_option) begin
			option_r <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Edge detection and timer0 clocking
	logic ext_edge;
	logic t0_pin_edge;
	logic t0_tick;
	logic pre_in;
	logic pre_out;
	logic t0_inc;
	logic pin_change;

	always_comb begin
		ext_edge    = option_r[OP_EDGE] ? (ext_irq_pin && !ext_pin_d_r)
		                                : (!ext_irq_pin && ext_pin_d_r);
		t0_pin_edge = option_r[OP_TIMER0_EDGE_SELECT] ? (!timer0_clock_pin && t0_pin_d_r)
		                                : (timer0_clock_pin && !t0_pin_d_r);
		t0_tick     = option_r[OP_TIMER0_CLOCK_SOURCE] ? t0_pin_edge : 1'b1;
		pre_in      = option_r[OP_PSA] ? watchdog_tick : t0_tick;
		t0_inc      = option_r[OP_PSA] ? t0_tick : pre_out;
		pin_change  = |((port_pins ^ port_d_r) & per_pin_change_mask);
	end

	prescaler_unit #(
		.WIDTH(8)
	) u_prescaler (
		.clk        (clk),
		.reset      (reset),
		.tick_in    (pre_in),
		.rate       (option_r[OP_RATE_LO +: 3]),
		.to_watchdog(option_r[OP_PSA]),
		.tick_out   (pre_out)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			ext_pin_d_r <= 1'b0;
			t0_pin_d_r  <= 1'b0;
			port_d_r    <= 6'h00;
		end else begin
			ext_pin_d_r <= ext_irq_pin;
			t0_pin_d_r  <= timer0_clock_pin;
			port_d_r    <= port_pins;
		end
	end

	// Count survives reset on purpose; no register write path loads it
	always_ff @(posedge clk) begin
		if (t0_inc) begin
			timer0_r <= timer0_r + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt control and peripheral registers
	logic t0_ovf;
	assign t0_ovf = t0_inc && (timer0_r == 8'hFF);

	always_ff @(posedge clk) begin
		if (reset) begin
			irqctl_r <= IRQCTL_RESET;
		end else begin
			if (wr_irqctl) begin
				irqctl_r <= reg_wdata;
			end
			// Hardware set wins over a same-cycle software clear
			if (t0_ovf)     irqctl_r[IC_T0F]  <= 1'b1;
			if (ext_edge)   irqctl_r[IC_EXTF] <= 1'b1;
			if (pin_change) irqctl_r[IC_PCF]  <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pie_r <= PERIPH_RESET;
			pir_r <= PERIPH_RESET;
		end else begin
			if (wr_pie) begin
				pie_r <= reg_wdata & PERIPH_IMPL_MASK;
			end
			pir_r <= ((wr_pir ? reg_wdata : pir_r) | periph_events) & PERIPH_IMPL_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all registered
	logic core_pend;
	logic per_pend;
	assign core_pend = |(irqctl_r[5:3] & irqctl_r[2:0]);
	assign per_pend  = irqctl_r[IC_PERIPHERAL_IRQ_GATE] && |(pie_r & pir_r);

	always_ff @(posedge clk) begin
		if (reset) begin
			cpu_irq              <= 1'b0;
			pullup_on            <= 6'h00;
			bank_select          <= 1'b0;
			timer0               <= 8'h00;
			watchdog_tick_scaled <= 1'b0;
		end else begin
			cpu_irq              <= irqctl_r[IC_GIE] && (core_pend || per_pend);
			pullup_on            <= option_r[OP_PUOFF] ? 6'h00 : weak_pullup_enable;
			bank_select          <= status_r[ST_BANK];
			timer0               <= timer0_r;
			watchdog_tick_scaled <= option_r[OP_PSA] ? pre_out : watchdog_tick;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			case (reg_addr)
				ADDR_CPU_STATUS, ADDR_CPU_STATUS_HI:   reg_rdata <= status_r;
				ADDR_IRQ_CONTROL, ADDR_IRQ_CONTROL_HI: reg_rdata <= irqctl_r;
				ADDR_TIMER_OPTION:                     reg_rdata <= option_r;
				ADDR_PERIPH_ENABLE:                    reg_rdata <= pie_r;
				ADDR_PERIPH_FLAGS:                     reg_rdata <= pir_r;
				default:                               reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_sleep_clears_flag: assert property (@(posedge clk) disable iff (reset)
		core_event.sleep |=> !status_r[ST_SLEEPN]) else $error("sleep flag not cleared");
	a_timeout_flag: assert property (@(posedge clk) disable iff (reset)
		core_event.wdog_timeout |=> !status_r[ST_WDOGN]) else $error("watchdog flag not cleared");
	a_sw_no_wdog_flag: assert property (@(posedge clk) disable iff (reset)
		wr_status && !core_event.wdog_timeout && !core_event.sleep && !core_event.wdog_clear
		|=> $stable(status_r[4:3])) else $error("software changed hardware flags");
	a_zero_flag: assert property (@(posedge clk) disable iff (reset)
		alu_op.valid && alu_op.upd_zero |=> status_r[ST_ZERO] == $past(result == 8'h00))
		else $error("zero flag wrong");
	a_carry_flag: assert property (@(posedge clk) disable iff (reset)
		alu_op.valid && alu_op.upd_carries && alu_op.kind == ALU_ADD
		|=> status_r[ST_CARRY] == $past(({1'b0, alu_op.opa} + {1'b0, alu_op.opb}) > 9'h0FF))
		else $error("carry flag wrong");
	a_ext_flag_set: assert property (@(posedge clk) disable iff (reset)
		ext_edge |=> irqctl_r[IC_EXTF]) else $error("external flag missed");
	a_irq_gated: assert property (@(posedge clk) disable iff (reset)
		!irqctl_r[IC_GIE] |=> !cpu_irq) else $error("irq without global enable");
	a_pullup_off: assert property (@(posedge clk) disable iff (reset)
		option_r[OP_PUOFF] |=> pullup_on == 6'h00) else $error("pull-ups not disabled");
	a_pie_bit4_zero: assert property (@(posedge clk) disable iff (reset)
		!pie_r[4] && !pir_r[4]) else $error("unimplemented bit set");
	a_timer0_ovf: assert property (@(posedge clk) disable iff (reset)
		t0_ovf |=> irqctl_r[IC_T0F] && timer0_r == 8'h00) else $error("rollover flag missed");

	// Request, routing and flag checks; the request lags its inputs by one cycle
	a_irq_request: assert property (@(posedge clk) disable iff (reset)
		1'b1 |=> cpu_irq == $past(irqctl_r[IC_GIE] && (|(irqctl_r[5:3] & irqctl_r[2:0])
		|| (irqctl_r[IC_PERIPHERAL_IRQ_GATE] && |(pie_r & pir_r))))) else $error("interrupt request wrong");
	a_pin_change_flag: assert property (@(posedge clk) disable iff (reset)
		pin_change |=> irqctl_r[IC_PCF])
		else $error("pin change flag missed");
	a_periph_flag_set: assert property (@(posedge clk) disable iff (reset)
		|(periph_events & PERIPH_IMPL_MASK)
		|=> (pir_r & $past(periph_events & PERIPH_IMPL_MASK)) == $past(periph_events & PERIPH_IMPL_MASK))
		else $error("peripheral flag missed");
	a_bank_out: assert property (@(posedge clk) disable iff (reset)
		1'b1 |=> bank_select == $past(status_r[ST_BANK]))
		else $error("bank select output wrong");
	a_t0_internal: assert property (@(posedge clk) disable iff (reset)
		!option_r[OP_TIMER0_CLOCK_SOURCE] |-> t0_tick)
		else $error("internal timer clock missing");
	a_t0_pin_fall: assert property (@(posedge clk) disable iff (reset)
		option_r[OP_TIMER0_CLOCK_SOURCE] && option_r[OP_TIMER0_EDGE_SELECT] && t0_pin_d_r && !timer0_clock_pin |-> t0_tick)
		else $error("falling timer edge missed");
	a_psa_route: assert property (@(posedge clk) disable iff (reset)
		option_r[OP_PSA] |-> t0_inc == t0_tick)
		else $error("prescaler routing wrong");
	a_dest_upper: assert property (@(posedge clk) disable iff (reset)
		alu_op.valid && alu_op.dest_status |=> status_r[7:5] == $past(alu_op.wr_data[7:5]))
		else $error("status destination write wrong");
	a_wdog_set: assert property (@(posedge clk) disable iff (reset)
		(core_event.wdog_clear || core_event.sleep) && !core_event.wdog_timeout |=> status_r[ST_WDOGN])
		else $error("watchdog flag not set");
	a_ext_flag_held: assert property (@(posedge clk) disable iff (reset)
		irqctl_r[IC_EXTF] && !wr_irqctl |=> irqctl_r[IC_EXTF])
		else $error("external flag dropped");
	a_pullup_follow: assert property (@(posedge clk) disable iff (reset)
		!option_r[OP_PUOFF] |=> pullup_on == $past(weak_pullup_enable))
		else $error("pull-ups not following enables");
	a_ext_rise_flag: assert property (@(posedge clk) disable iff (reset)
		option_r[OP_EDGE] && ext_irq_pin && !ext_pin_d_r |=> irqctl_r[IC_EXTF])
		else $error("rising external edge missed");
	a_sleep_flag_set: assert property (@(posedge clk) disable iff (reset)
		core_event.wdog_clear && !core_event.sleep |=> status_r[ST_SLEEPN])
		else $error("sleep flag not set");

	c_irq_raised: cover property (@(posedge clk) disable iff (reset) $rose(cpu_irq));
	c_sub_borrow: cover property (@(posedge clk) disable iff (reset)
		alu_op.valid && alu_op.kind == ALU_SUB && !sum9[8]);
	c_pin_change: cover property (@(posedge clk) disable iff (reset) pin_change);
	c_periph_irq: cover property (@(posedge clk) disable iff (reset) per_pend && irqctl_r[IC_GIE]);

endmodule : core_status_option_irq_regs

// ==== tb_core_status_option_irq_regs.sv ====
// Self-checking testbench for the core status, option and interrupt registers
`timescale 1ns/1ps
module tb_core_status_option_irq_regs
	import core_regs_pkg::*;
;
	logic        clk;
	logic        reset;
	logic        reg_write;
	logic        reg_read;
	logic        ext_irq_pin;
	logic        watchdog_tick;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic [7:0]  periph_events;
	logic [7:0]  timer0;
	logic [5:0]  port_pins;
	logic [5:0]  pullup_on;
	logic        bank_select;
	logic        scaled;
	logic        cpu_irq;
	alu_op_s     alu_op;
	core_event_s core_event;
	int          n_mismatch;
	int          n_checks;

	core_status_option_irq_regs core_status_option_irq_regs_inst (
		.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .alu_op(alu_op),
		.core_event(core_event), .ext_irq_pin(ext_irq_pin), .timer0_clock_pin(ext_irq_pin),
		.port_pins(port_pins), .per_pin_change_mask(6'h01), .weak_pullup_enable(6'h2A),
		.periph_events(periph_events), .watchdog_tick(watchdog_tick), .bank_select(bank_select),
		.pullup_on(pullup_on), .timer0(timer0), .watchdog_tick_scaled(scaled), .cpu_irq(cpu_irq)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rc(input string name, input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		chk(name, reg_rdata & m, exp);
	endtask : rc

	task automatic irq_is(input logic v);
		cyc(2);
		#1;
		chk("cpu_irq", {7'h00, cpu_irq}, {7'h00, v});
	endtask : irq_is

	task automatic set_pin(input logic v);
		@(posedge clk);
		ext_irq_pin <= v;
		cyc(3);
	endtask : set_pin

	task automatic pev(input logic [7:0] v);
		@(posedge clk);
		periph_events <= v;
		@(posedge clk);
		periph_events <= 8'h00;
	endtask : pev

	task automatic pulse_ev(input core_event_s e);
		@(posedge clk);
		core_event <= e;
		@(posedge clk);
		core_event <= '0;
	endtask : pulse_ev

	task automatic alu_go(input alu_kind_e k, input logic d, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] res, input logic uc);
		@(posedge clk);
		alu_op <= '{valid: 1'b1, dest_status: d, wr_data: 8'h00, upd_zero: 1'b1, upd_carries: uc,
			kind: k, opa: a, opb: b, logic_result: res};
		@(posedge clk);
		alu_op <= '0;
	endtask : alu_go

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rc("status", ADDR_CPU_STATUS, 8'hFF, 8'h18);
		rc("option", ADDR_TIMER_OPTION, 8'hFF, 8'hFF);
		rc("irqctl", ADDR_IRQ_CONTROL_HI, 8'hFF, 8'h00);
		rc("pie", ADDR_PERIPH_ENABLE, 8'hFF, 8'h00);
		rc("pir", ADDR_PERIPH_FLAGS, 8'hFF, 8'h00);
		rc("unmapped", 8'h55, 8'hFF, 8'h00);
	endtask : t_reset

	task automatic t_status();
		alu_kind_e  ks [4] = '{ALU_ADD, ALU_ADD, ALU_SUB, ALU_SUB};
		logic [7:0] as [4] = '{8'h0F, 8'hFF, 8'h05, 8'h06};
		logic [7:0] bs [4] = '{8'h01, 8'h01, 8'h06, 8'h05};
		logic [7:0] bb;
		logic [8:0] s;
		wr(ADDR_CPU_STATUS, 8'h27);
		rc("status_wr", ADDR_CPU_STATUS_HI, 8'hF8, 8'h38);
		chk("bank_select", {7'h00, bank_select}, 8'h01);
		for (int i = 0; i < 4; i++) begin
			bb = (ks[i] == ALU_SUB) ? ~bs[i] + 8'h01 : bs[i];
			s = {1'b0, as[i]} + {1'b0, bb};
			alu_go(ks[i], 1'b0, as[i], bs[i], s[7:0], 1'b1);
			rc("alu_flags", ADDR_CPU_STATUS, 8'h07, {5'h00, s[7:0] == 8'h00,
				({1'b0, as[i][3:0]} + {1'b0, bb[3:0]}) > 5'h0F, s[8]});
		end
		// A clear aimed at the status register still ends with the zero flag set
		alu_go(ALU_LOGIC, 1'b1, 8'h00, 8'h00, 8'h00, 1'b0);
		rc("clr_status", ADDR_CPU_STATUS, 8'hFF, 8'h1F);
		chk("bank_select", {7'h00, bank_select}, 8'h00);
	endtask : t_status

	task automatic t_events();
		core_event_s ev [5] = '{3'b010, 3'b001, 3'b100, 3'b001, 3'b010};
		logic [7:0]  ex [5] = '{8'h10, 8'h00, 8'h18, 8'h08, 8'h10};
		for (int i = 0; i < 5; i++) begin
			pulse_ev(ev[i]);
			rc("wd_sleep", ADDR_CPU_STATUS, 8'h18, ex[i]);
		end
	endtask : t_events

	task automatic t_ext();
		wr(ADDR_TIMER_OPTION, 8'h48);
		wr(ADDR_IRQ_CONTROL, 8'h10);
		set_pin(1'b1);
		rc("ext_rise", ADDR_IRQ_CONTROL, 8'hFF, 8'h12);
		irq_is(1'b0);
		wr(ADDR_IRQ_CONTROL, 8'h92);
		irq_is(1'b1);
		set_pin(1'b0);
		rc("ext_held", ADDR_IRQ_CONTROL, 8'hFF, 8'h92);
		wr(ADDR_IRQ_CONTROL, 8'h90);
		irq_is(1'b0);
		wr(ADDR_TIMER_OPTION, 8'h08);
		set_pin(1'b1);
		rc("ext_rise_off", ADDR_IRQ_CONTROL, 8'hFF, 8'h90);
		set_pin(1'b0);
		rc("ext_fall", ADDR_IRQ_CONTROL, 8'hFF, 8'h92);
		wr(ADDR_IRQ_CONTROL, 8'h00);
	endtask : t_ext

	task automatic t_pin_change();
		@(posedge clk);
		port_pins <= 6'h02;
		cyc(3);
		rc("pc_masked", ADDR_IRQ_CONTROL, 8'h01, 8'h00);
		@(posedge clk);
		port_pins <= 6'h03;
		cyc(3);
		rc("pc_set", ADDR_IRQ_CONTROL, 8'h01, 8'h01);
		wr(ADDR_IRQ_CONTROL, 8'h00);
		rc("pc_clear", ADDR_IRQ_CONTROL, 8'h01, 8'h00);
	endtask : t_pin_change

	task automatic t_periph();
		wr(ADDR_PERIPH_ENABLE, 8'hFF);
		rc("pie", ADDR_PERIPH_ENABLE, 8'hFF, 8'hEF);
		pev(8'h10);
		rc("pir_gap", ADDR_PERIPH_FLAGS, 8'hFF, 8'h00);
		pev(8'h01);
		rc("pir", ADDR_PERIPH_FLAGS, 8'hFF, 8'h01);
		wr(ADDR_IRQ_CONTROL, 8'h80);
		irq_is(1'b0);
		wr(ADDR_IRQ_CONTROL, 8'hC0);
		irq_is(1'b1);
		wr(ADDR_PERIPH_ENABLE, 8'h00);
		irq_is(1'b0);
		wr(ADDR_PERIPH_FLAGS, 8'h00);
		wr(ADDR_IRQ_CONTROL, 8'h00);
	endtask : t_periph

	task automatic t_pullups();
		cyc(2);
		#1;
		chk("pullup_on", {2'b00, pullup_on}, 8'h2A);
		wr(ADDR_TIMER_OPTION, 8'h88);
		cyc(2);
		#1;
		chk("pullup_off", {2'b00, pullup_on}, 8'h00);
	endtask : t_pullups

	// Sixteen back-to-back ticks give a whole number of periods, whatever phase the counter holds
	task automatic pscale(input logic [7:0] opt, input logic [7:0] exp);
		logic [7:0] n;
		n = 8'h00;
		wr(ADDR_TIMER_OPTION, opt);
		@(posedge clk);
		watchdog_tick <= 1'b1;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			if (i == 15)
				watchdog_tick <= 1'b0;
			#1;
			if (scaled === 1'b1)
				n++;
		end
		chk("wdog_ticks", n, exp);
	endtask : pscale

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		#(60000 * 50);
		n_mismatch++;
		complete_run();
	end

	initial begin
		n_mismatch = 0;
		n_checks = 0;
		reset = 1'b1;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		ext_irq_pin = 1'b0;
		watchdog_tick = 1'b0;
		periph_events = 8'h00;
		port_pins = 6'h00;
		alu_op = '0;
		core_event = '0;
		cyc(6);
		reset <= 1'b0;
		t_reset();
		t_status();
		t_events();
		t_ext();
		t_pin_change();
		t_periph();
		t_pullups();
		pscale(8'h08, 8'h10);
		pscale(8'h0B, 8'h02);
		pscale(8'h02, 8'h10);
		complete_run();
	end
endmodule : tb_core_status_option_irq_regs
